// *** rtl/sync_serial_receiver.sv ***
// Synchronous-mode receive path with APB register access
`timescale 1ns/1ns
module sync_serial_receiver (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe
);
  // =====================================================================
  // Declarations
  logic port_enable_q;
  logic nine_bit_receive_enable_q;
  logic single_receive_enable_q;
  logic continuous_receive_enable_q;
  logic overrun_error_flag_q;
  logic overrun_in_continuous_q;
  logic clock_source_master_q;
  logic sync_mode_q;
  logic high_rate_select_q;
  logic data_polarity_select_q;
  logic clock_polarity_select_q;
  logic wide_divisor_select_q;
  logic [7:0] baud_divisor_low_q;
  logic [7:0] baud_divisor_high_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic pop_ok_q;
  logic clk_s1_q;
  logic clk_s2_q;
  logic data_s1_q;
  logic data_s2_q;
  logic clk_lvl_prev_q;
  logic clk_gen_q;
  logic clk_out_q;
  logic clk_oe_q;
  logic data_out_q;
  logic data_oe_q;
  logic [8:0] receive_shift_register_q;
  logic [3:0] bit_cnt_q;
  sync_rx_pkg::rx_state_t state_q;
  logic access;
  logic done;
  logic wr_done;
  logic pop_done;
  logic mapped;
  logic [7:0] rd_byte;
  logic rx_on;
  logic master_on;
  logic tick;
  logic clk_lvl;
  logic trailing;
  logic bit_in;
  logic [3:0] char_bits;
  logic last_bit;
  logic char_done;
  logic [8:0] shift_next;
  logic [15:0] divisor;

  rx_queue_if qif ();

  // =====================================================================
  // Register decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  assign access = psel & penable;
  assign done = access & pready_q;
  assign wr_done = done & pwrite;
  // Pop only if a character was present when read data was captured
  assign pop_done = done & pop_ok_q;

  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      sync_rx_pkg::BAUD_CONTROL_OFS: begin
        rd_byte[sync_rx_pkg::BDC_RECEIVE_IDLE] = (state_q == sync_rx_pkg::RX_IDLE);
        rd_byte[sync_rx_pkg::BDC_DATA_POLARITY] = data_polarity_select_q;
        rd_byte[sync_rx_pkg::BDC_CLOCK_POLARITY] = clock_polarity_select_q;
        rd_byte[sync_rx_pkg::BDC_WIDE_DIVISOR] = wide_divisor_select_q;
      end
      sync_rx_pkg::RECEIVE_STATUS_CONTROL_OFS: begin
        rd_byte[sync_rx_pkg::RCS_PORT_ENABLE] = port_enable_q;
        rd_byte[sync_rx_pkg::RCS_NINE_BIT] = nine_bit_receive_enable_q;
        rd_byte[sync_rx_pkg::RCS_SINGLE] = single_receive_enable_q;
        rd_byte[sync_rx_pkg::RCS_CONTINUOUS] = continuous_receive_enable_q;
        rd_byte[sync_rx_pkg::RCS_OVERRUN] = overrun_error_flag_q;
        rd_byte[sync_rx_pkg::RCS_NINTH_BIT] = qif.head[8];
      end
      sync_rx_pkg::BAUD_DIVISOR_LOW_OFS: rd_byte = baud_divisor_low_q;
      sync_rx_pkg::BAUD_DIVISOR_HIGH_OFS: rd_byte = baud_divisor_high_q;
      sync_rx_pkg::TRANSMIT_DATA_OFS: rd_byte = 8'h00;
      sync_rx_pkg::TRANSMIT_STATUS_CONTROL_OFS: begin
        rd_byte[sync_rx_pkg::TXS_CLOCK_SOURCE] = clock_source_master_q;
        rd_byte[sync_rx_pkg::TXS_SYNC_MODE] = sync_mode_q;
        rd_byte[sync_rx_pkg::TXS_HIGH_RATE] = high_rate_select_q;
        rd_byte[sync_rx_pkg::TXS_SHIFT_IDLE] = 1'b1;
      end
      sync_rx_pkg::RECEIVE_DATA_OFS: rd_byte = qif.head[7:0];
      sync_rx_pkg::RECEIVE_FLAGS_OFS: begin
        rd_byte[sync_rx_pkg::FLG_RECEIVE_COMPLETE] = ~qif.empty;
      end
      default: mapped = 1'b0;
    endcase
  end

  // =====================================================================
  // APB slave: answers on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pop_ok_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      if (access & ~pready_q) begin
        prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pop_ok_q <= ~pwrite & hit(paddr, sync_rx_pkg::RECEIVE_DATA_OFS) & ~qif.empty;
      end else begin
        pop_ok_q <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_master_q <= sync_rx_pkg::TRANSMIT_STATUS_CONTROL_RESET[7];
      sync_mode_q <= sync_rx_pkg::TRANSMIT_STATUS_CONTROL_RESET[4];
      high_rate_select_q <= sync_rx_pkg::TRANSMIT_STATUS_CONTROL_RESET[2];
    end else if (wr_done & hit(paddr, sync_rx_pkg::TRANSMIT_STATUS_CONTROL_OFS)) begin
      clock_source_master_q <= pwdata[sync_rx_pkg::TXS_CLOCK_SOURCE];
      sync_mode_q <= pwdata[sync_rx_pkg::TXS_SYNC_MODE];
      high_rate_select_q <= pwdata[sync_rx_pkg::TXS_HIGH_RATE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_polarity_select_q <= sync_rx_pkg::BAUD_CONTROL_RESET[5];
      clock_polarity_select_q <= sync_rx_pkg::BAUD_CONTROL_RESET[4];
      wide_divisor_select_q <= sync_rx_pkg::BAUD_CONTROL_RESET[3];
    end else if (wr_done & hit(paddr, sync_rx_pkg::BAUD_CONTROL_OFS)) begin
      data_polarity_select_q <= pwdata[sync_rx_pkg::BDC_DATA_POLARITY];
      clock_polarity_select_q <= pwdata[sync_rx_pkg::BDC_CLOCK_POLARITY];
      wide_divisor_select_q <= pwdata[sync_rx_pkg::BDC_WIDE_DIVISOR];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_divisor_low_q <= sync_rx_pkg::BAUD_DIVISOR_RESET;
      baud_divisor_high_q <= sync_rx_pkg::BAUD_DIVISOR_RESET;
    end else if (wr_done) begin
      if (hit(paddr, sync_rx_pkg::BAUD_DIVISOR_LOW_OFS)) baud_divisor_low_q <= pwdata[7:0];
      if (hit(paddr, sync_rx_pkg::BAUD_DIVISOR_HIGH_OFS)) baud_divisor_high_q <= pwdata[7:0];
    end
  end

  // Software write beats the self-clear of single receive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_enable_q <= sync_rx_pkg::RECEIVE_STATUS_CONTROL_RESET[7];
      nine_bit_receive_enable_q <= sync_rx_pkg::RECEIVE_STATUS_CONTROL_RESET[6];
      single_receive_enable_q <= sync_rx_pkg::RECEIVE_STATUS_CONTROL_RESET[5];
      continuous_receive_enable_q <= sync_rx_pkg::RECEIVE_STATUS_CONTROL_RESET[4];
    end else if (wr_done & hit(paddr, sync_rx_pkg::RECEIVE_STATUS_CONTROL_OFS)) begin
      port_enable_q <= pwdata[sync_rx_pkg::RCS_PORT_ENABLE];
      nine_bit_receive_enable_q <= pwdata[sync_rx_pkg::RCS_NINE_BIT];
      single_receive_enable_q <= pwdata[sync_rx_pkg::RCS_SINGLE];
      continuous_receive_enable_q <= pwdata[sync_rx_pkg::RCS_CONTINUOUS];
    end else if (char_done) begin
      single_receive_enable_q <= 1'b0;
    end
  end

  // =====================================================================
  // Overrun tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_flag_q <= 1'b0;
      overrun_in_continuous_q <= 1'b0;
    end else if (!port_enable_q) begin
      overrun_error_flag_q <= 1'b0;
      overrun_in_continuous_q <= 1'b0;
    end else if (char_done & qif.full) begin
      overrun_error_flag_q <= 1'b1;
      overrun_in_continuous_q <= continuous_receive_enable_q;
    end else if (overrun_error_flag_q & ~overrun_in_continuous_q & pop_done) begin
      overrun_error_flag_q <= 1'b0;
    end else if (overrun_error_flag_q & overrun_in_continuous_q
                 & ~continuous_receive_enable_q) begin
      overrun_error_flag_q <= 1'b0;
      overrun_in_continuous_q <= 1'b0;
    end
  end

  // =====================================================================
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      data_s1_q <= 1'b0;
      data_s2_q <= 1'b0;
    end else begin
      clk_s1_q <= serial_clock_line_in;
      clk_s2_q <= clk_s1_q;
      data_s1_q <= serial_data_line_in;
      data_s2_q <= data_s1_q;
    end
  end

  // =====================================================================
  // Receive control
  // Overrun blocks reception until cleared
  assign rx_on = port_enable_q & sync_mode_q & ~overrun_error_flag_q
                 & (single_receive_enable_q | continuous_receive_enable_q);
  assign master_on = rx_on & clock_source_master_q;
  assign divisor = wide_divisor_select_q ? {baud_divisor_high_q, baud_divisor_low_q}
                                         : {8'h00, baud_divisor_low_q};

  baud_tick_gen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .enable(master_on),
    .divisor(divisor),
    .tick(tick)
  );

  // Polarity folded out so that the logical clock idles low
  assign clk_lvl = clk_s2_q ^ clock_polarity_select_q;
  assign trailing = clock_source_master_q ? (tick & clk_gen_q)
                                          : (clk_lvl_prev_q & ~clk_lvl);
  assign bit_in = data_s2_q ^ data_polarity_select_q;
  assign char_bits = nine_bit_receive_enable_q ? sync_rx_pkg::CHAR_BITS_9
                                               : sync_rx_pkg::CHAR_BITS_8;
  assign last_bit = (bit_cnt_q == char_bits - 4'h1);
  assign char_done = rx_on & trailing & last_bit;
  assign shift_next = {bit_in, receive_shift_register_q[8:1]};

  // Master clock: toggles each tick, idle low when not receiving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_gen_q <= 1'b0;
    end else if (!master_on) begin
      clk_gen_q <= 1'b0;
    end else if (tick) begin
      clk_gen_q <= ~clk_gen_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_lvl_prev_q <= 1'b0;
    end else begin
      clk_lvl_prev_q <= clk_lvl;
    end
  end

  // Shift register; a dropped enable discards the partial character
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_shift_register_q <= 9'h000;
      bit_cnt_q <= 4'h0;
      state_q <= sync_rx_pkg::RX_IDLE;
    end else if (!rx_on) begin
      bit_cnt_q <= 4'h0;
      state_q <= sync_rx_pkg::RX_IDLE;
    end else if (trailing) begin
      receive_shift_register_q <= shift_next;
      case (state_q)
        sync_rx_pkg::RX_IDLE: begin
          bit_cnt_q <= 4'h1;
          state_q <= sync_rx_pkg::RX_SHIFT;
        end
        sync_rx_pkg::RX_SHIFT: begin
          if (last_bit) begin
            bit_cnt_q <= 4'h0;
            state_q <= sync_rx_pkg::RX_IDLE;
          end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        default: begin
          bit_cnt_q <= 4'h0;
          state_q <= sync_rx_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // Queue hookup
  assign qif.push = char_done & ~qif.full;
  assign qif.wdata = nine_bit_receive_enable_q ? shift_next : {1'b0, shift_next[8:1]};
  assign qif.pop = pop_done;
  assign qif.flush = ~port_enable_q;

  rx_queue u_queue (
    .pclk(pclk),
    .presetn(presetn),
    .q(qif)
  );

  // =====================================================================
  // Pin drivers; data line is only listened to while receiving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out_q <= 1'b0;
      clk_oe_q <= 1'b0;
      data_out_q <= 1'b0;
      data_oe_q <= 1'b0;
    end else begin
      clk_out_q <= clk_gen_q ^ clock_polarity_select_q;
      clk_oe_q <= port_enable_q & sync_mode_q & clock_source_master_q;
      data_out_q <= 1'b0;
      data_oe_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_clock_line_out = clk_out_q;
  assign serial_clock_line_oe = clk_oe_q;
  assign serial_data_line_out = data_out_q;
  assign serial_data_line_oe = data_oe_q;
endmodule // sync_serial_receiver

// *** inc/sync_rx_pkg.sv ***
// Constants, register map and types for the synchronous serial receiver
// =====================================================================
// Summary of operation
// - Either receive enable starts synchronous reception
// - Single receive: one character, then self-clears
// - Continuous receive: master clocks until cleared
// - Continuous cleared mid-character: stop clock, discard
// - Both set: single clears after first character
// - Sample data on trailing clock edge
// - Full character sets flag, enters queue
// - Data register shows oldest character low byte
// - Complete flag holds while queue nonempty
// - Slave takes external clock, driver off
// - Data changes leading edge, one bit/clock
// - Third character with full queue sets overrun
// - Overrun keeps queue, blocks further reception
// - Single-mode overrun cleared by data read
// - Continuous overrun cleared by clearing enables
// - Nine-bit option shifts nine bits
// - Ninth bit field shows oldest character's bit
// - Slave: sync set, source clear, port enabled
// - Both enables clear means transmit direction; here the data line stays undriven, nothing is sent
// - Master drives one clock per data bit
// - Clock polarity sets idle level and edges
// - Data polarity defaults clear, inverts data
package sync_rx_pkg;
  // =====================================================================
  // Register byte addresses
  localparam logic [7:0] BAUD_CONTROL_OFS = 8'h00;
  localparam logic [7:0] RECEIVE_STATUS_CONTROL_OFS = 8'h04;
  localparam logic [7:0] BAUD_DIVISOR_LOW_OFS = 8'h08;
  localparam logic [7:0] BAUD_DIVISOR_HIGH_OFS = 8'h0C;
  localparam logic [7:0] TRANSMIT_DATA_OFS = 8'h10;
  localparam logic [7:0] TRANSMIT_STATUS_CONTROL_OFS = 8'h14;
  localparam logic [7:0] RECEIVE_DATA_OFS = 8'h18;
  localparam logic [7:0] RECEIVE_FLAGS_OFS = 8'h1C;
  // =====================================================================
  // Field positions
  localparam int RCS_PORT_ENABLE = 7;
  localparam int RCS_NINE_BIT = 6;
  localparam int RCS_SINGLE = 5;
  localparam int RCS_CONTINUOUS = 4;
  localparam int RCS_OVERRUN = 1;
  localparam int RCS_NINTH_BIT = 0;
  localparam int TXS_CLOCK_SOURCE = 7;
  localparam int TXS_SYNC_MODE = 4;
  localparam int TXS_HIGH_RATE = 2;
  localparam int TXS_SHIFT_IDLE = 1;
  localparam int BDC_RECEIVE_IDLE = 6;
  localparam int BDC_DATA_POLARITY = 5;
  localparam int BDC_CLOCK_POLARITY = 4;
  localparam int BDC_WIDE_DIVISOR = 3;
  localparam int FLG_RECEIVE_COMPLETE = 0;
  // =====================================================================
  // Reset values and counts
  localparam logic [7:0] RECEIVE_STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TRANSMIT_STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] BAUD_CONTROL_RESET = 8'h00;
  localparam logic [7:0] BAUD_DIVISOR_RESET = 8'h00;
  localparam logic [3:0] CHAR_BITS_8 = 4'h8;
  localparam logic [3:0] CHAR_BITS_9 = 4'h9;
  localparam int CHAR_W = 9;
  localparam int QUEUE_DEPTH = 2;
  typedef enum logic {RX_IDLE, RX_SHIFT} rx_state_t;
endpackage

// *** inc/rx_queue_if.sv ***
// Push/pop connection between the receiver and its character queue
`timescale 1ns/1ns
interface rx_queue_if;
  logic push;
  logic pop;
  logic flush;
  logic [8:0] wdata;
  logic [8:0] head;
  logic empty;
  logic full;
  modport owner (input push, input pop, input flush, input wdata,
                 output head, output empty, output full);
  modport user (output push, output pop, output flush, output wdata,
                input head, input empty, input full);
endinterface

// *** rtl/rx_queue.sv ***
// Two-character receive queue
`timescale 1ns/1ns
module rx_queue (
  input wire logic pclk,
  input wire logic presetn,
  rx_queue_if.owner q
);
  // =====================================================================
  // Storage
  logic [sync_rx_pkg::CHAR_W-1:0] mem_q [sync_rx_pkg::QUEUE_DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic do_push;
  logic do_pop;

  // Push and pop may meet in one cycle; both take effect unless the queue is full or empty
  assign do_push = q.push & (count_q != 2'h2);
  assign do_pop = q.pop & (count_q != 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (q.flush) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (do_push) wr_ptr_q <= ~wr_ptr_q;
      if (do_pop) rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  always_ff @(posedge pclk) begin
    if (do_push) mem_q[wr_ptr_q] <= q.wdata;
  end

  assign q.head = (count_q == 2'h0) ? 9'h000 : mem_q[rd_ptr_q];
  assign q.empty = (count_q == 2'h0);
  assign q.full = (count_q == 2'h2);
endmodule // rx_queue

// *** rtl/baud_tick_gen.sv ***
// Divisor-based half-bit enable for the master serial clock
`timescale 1ns/1ns
module baud_tick_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [15:0] divisor,
  output logic tick
);
  logic [15:0] cnt_q;
  logic tick_q;

  // One pulse every divisor+1 cycles; restarts whenever disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (!enable) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (cnt_q >= divisor) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;
endmodule // baud_tick_gen

// *** sim/sync_serial_receiver_checker.sv ***
// Port assertions for the synchronous serial receiver
`timescale 1ns/1ns
module sync_serial_receiver_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_clock_line_in,
  input wire logic serial_clock_line_out,
  input wire logic serial_clock_line_oe,
  input wire logic serial_data_line_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe
);
  // =====================================================================
  // Shadows of control writes
  logic acc, wr04, lead, mst_q, pol_q, pen_q, sgl_q, cont_q, nine_q, ck_q;
  logic [3:0] lead_q;
  assign acc = psel && penable && pready;
  assign wr04 = acc && pwrite && paddr == 8'h04;
  assign lead = serial_clock_line_oe && (serial_clock_line_out ^ pol_q) && !ck_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mst_q, pol_q, pen_q, nine_q, sgl_q, cont_q} <= 6'h0;
    end else if (acc && pwrite) begin
      if (paddr == 8'h14) mst_q <= pwdata[7];
      if (paddr == 8'h00) pol_q <= pwdata[4];
      if (wr04) {pen_q, nine_q, sgl_q, cont_q} <= pwdata[7:4];
    end
  end
  // Leading edges since last receive status control write (0x04); saturation keeps a fail
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_q <= 1'h0;
      lead_q <= 4'h0;
    end else begin
      ck_q <= serial_clock_line_out ^ pol_q;
      if (wr04) lead_q <= 4'h0;
      else if (lead && lead_q != 4'hF) lead_q <= lead_q + 4'h1;
    end
  end
  // =====================================================================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unm; acc && (paddr > 8'h1C || paddr[1:0] != 2'h0) |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_hi; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_dat; !serial_data_line_oe && !serial_data_line_out; endproperty
  a_dat: assert property (p_dat) else $error("data line driven");
  property p_slv; !mst_q && !$past(mst_q) && !$past(mst_q, 2) |-> !serial_clock_line_oe; endproperty
  a_slv: assert property (p_slv) else $error("slave drives clock");
  property p_stop; wr04 && !pwdata[5] && !pwdata[4] |-> ##3 (serial_clock_line_out == pol_q) [*8]; endproperty
  a_stop: assert property (p_stop) else $error("clock not stopped");
  property p_sgl; sgl_q && !cont_q |-> lead_q <= (nine_q ? 4'h9 : 4'h8); endproperty
  a_sgl: assert property (p_sgl) else $error("too many clocks");
  property p_dis; acc && !pwrite && paddr == 8'h1C && !pen_q |-> prdata == 32'h0; endproperty
  a_dis: assert property (p_dis) else $error("queue kept while off");
  c_sgl: cover property (wr04 && pwdata[5]);
  c_lead: cover property (lead && lead_q == 4'h7);
  c_unm: cover property (acc && pslverr);
endmodule // sync_serial_receiver_checker

bind sync_serial_receiver sync_serial_receiver_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_clock_line_in(serial_clock_line_in), .serial_clock_line_out(serial_clock_line_out),
  .serial_clock_line_oe(serial_clock_line_oe), .serial_data_line_in(serial_data_line_in),
  .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe));

// *** sim/sync_peer_model.sv ***
// Far-side serial peer: follows a clock master or acts as one
`timescale 1ns/1ns
module sync_peer_model (
  input wire logic ck_wire,
  input wire logic dut_drives,
  input wire logic pol,
  input wire logic dpol,
  input wire logic [3:0] nbits,
  output logic ck_drv,
  output logic dat
);
  // =====================================================================
  // Character source, least significant bit first
  logic [8:0] q[$];
  int bi;
  initial begin
    ck_drv = 1'h0;
    dat = 1'h1;
    bi = 0;
  end
  // An idle data line toggles so stale bits never look valid
  always @(ck_wire) begin
    if (dut_drives && (ck_wire ^ pol) && q.size() > 0) begin
      dat = q[0][bi] ^ dpol;
      bi++;
      if (bi == nbits) begin
        void'(q.pop_front());
        bi = 0;
      end
    end else if (dut_drives && (ck_wire ^ pol)) begin
      dat = ~dat;
    end
  end
  // Clock master role: one clock per data bit, still between frames
  task automatic send(input logic [8:0] wd);
    for (int i = 0; i < nbits; i++) begin
      ck_drv = ~pol;
      dat = wd[i] ^ dpol;
      #62;
      ck_drv = pol;
      #63;
    end
    dat = ~dat;
  endtask
endmodule // sync_peer_model

// *** sim/tb.sv ***
// Self-checking bench for the synchronous serial receiver
`timescale 1ns/1ns
module tb;
  // =====================================================================
  // Signals, design and peer
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
  logic ck_out, ck_oe, dt_out, dt_oe, ck_drv, dt, ck_wire, dt_wire, pol, dpol;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0] nbits;
  logic [8:0] w;
  int failures, cmp_count, pulses, p;
  int exp_q[$];
  assign ck_wire = ck_oe ? ck_out : ck_drv;
  assign dt_wire = dt_oe ? dt_out : dt;
  sync_serial_receiver dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clock_line_in(ck_wire), .serial_clock_line_out(ck_out),
    .serial_clock_line_oe(ck_oe), .serial_data_line_in(dt_wire),
    .serial_data_line_out(dt_out), .serial_data_line_oe(dt_oe));
  sync_peer_model peer_u (.ck_wire(ck_wire), .dut_drives(ck_oe), .pol(pol), .dpol(dpol),
    .nbits(nbits), .ck_drv(ck_drv), .dat(dt));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge ck_wire) if (ck_oe) pulses++;
  // =====================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] ev, input logic [31:0] sv);
    cmp_count++;
    if (sv !== ev) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, ev, sv);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1);
    chk("ready", 32'h2, 32'(n));
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ev);
    apb(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), ev, rd_v);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'h0, a, 32'h0);
      n++;
    end while (rd_v[b] !== v && n < 400);
    chk("poll", 32'(v), 32'(rd_v[b]));
  endtask
  function automatic logic [31:0] nb();
    return 32'((exp_q[0] >> 8) & 1);
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
  // =====================================================================
  // Tests
  initial begin
    {presetn, psel, penable, pwrite, pol, dpol} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    nbits = 4'h8;
    failures = 0;
    cmp_count = 0;
    pulses = 0;
    void'($urandom(34));
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 9; i++) begin
      rd(8'(4 * i), (i == 5) ? 32'h2 : (i == 0) ? 32'h40 : 32'h0);
      chk("slave error", 32'(i == 8), 32'(err_v));
    end
    $display("test registers done");
    apb(1'h1, 8'h08, 32'h3);
    apb(1'h1, 8'h14, 32'h90);
    apb(1'h1, 8'h04, 32'h80);
    for (int i = 0; i < 3; i++) begin
      w = 9'($urandom_range(255));
      peer_u.q.push_back(w);
      if (i < 2) exp_q.push_back(w);
      pulses = 0;
      apb(1'h1, 8'h04, 32'hA0);
      poll(8'h04, 5, 1'h0);
      repeat (20) @(posedge pclk);
      chk("pulses", 32'h8, pulses);
    end
    rd(8'h04, 32'h82);
    rd(8'h1C, 32'h1);
    rd(8'h18, exp_q.pop_front() & 32'hFF);
    rd(8'h04, 32'h80);
    rd(8'h1C, 32'h1);
    rd(8'h18, exp_q.pop_front() & 32'hFF);
    rd(8'h1C, 32'h0);
    $display("test single done");
    peer_u.q.push_back(9'($urandom_range(255)));
    pulses = 0;
    apb(1'h1, 8'h04, 32'h90);
    for (int n = 0; n < 200 && pulses < 3; n++) @(posedge pclk);
    apb(1'h1, 8'h04, 32'h80);
    repeat (3) @(posedge pclk);
    p = pulses;
    repeat (40) @(posedge pclk);
    chk("pulses", p, pulses);
    rd(8'h1C, 32'h0);
    peer_u.q.delete();
    peer_u.bi = 0;
    $display("test abort done");
    apb(1'h1, 8'h00, 32'h30);
    pol <= 1'h1;
    dpol <= 1'h1;
    nbits = 4'h9;
    for (int i = 0; i < 3; i++) begin
      w = 9'($urandom_range(511));
      peer_u.q.push_back(w);
      if (i < 2) exp_q.push_back(w);
    end
    apb(1'h1, 8'h04, 32'hF0);
    poll(8'h04, 1, 1'h1);
    rd(8'h04, 32'hD2 | nb());
    rd(8'h18, exp_q.pop_front() & 32'hFF);
    rd(8'h04, 32'hD2 | nb());
    apb(1'h1, 8'h04, 32'hC0);
    rd(8'h04, 32'hC0 | nb());
    rd(8'h18, exp_q.pop_front() & 32'hFF);
    rd(8'h1C, 32'h0);
    $display("test nine bit done");
    apb(1'h1, 8'h00, 32'h0);
    pol <= 1'h0;
    dpol <= 1'h0;
    apb(1'h1, 8'h04, 32'h0);
    apb(1'h1, 8'h14, 32'h10);
    apb(1'h1, 8'h04, 32'hD0);
    for (int i = 0; i < 2; i++) begin
      w = 9'($urandom_range(511));
      exp_q.push_back(w);
      peer_u.send(w);
      chk("clock drive", 32'h0, 32'(ck_oe));
    end
    repeat (10) @(posedge pclk);
    rd(8'h04, 32'hD0 | nb());
    rd(8'h18, exp_q.pop_front() & 32'hFF);
    rd(8'h1C, 32'h1);
    apb(1'h1, 8'h04, 32'h0);
    exp_q.delete();
    rd(8'h1C, 32'h0);
    $display("test slave done");
    give_verdict();
  end
endmodule // tb
